// ### hdl/htbi_device.sv
// Data pump end: interface memory registers and transmit byte serializer.
`timescale 1ns/1ps
module htbi_device #(
  parameter int TONE_SHORT = htbi_pkg::TONE_SHORT_CYC, // 7 ms in clocks
  parameter int TONE_LONG = htbi_pkg::TONE_LONG_CYC // 30 ms in clocks
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  htbi_if.device link,
  input wire logic tx_bit_req_i,
  input wire logic flag_pattern_i,
  output logic tx_bit_o,
  output logic frame_end_o,
  output logic tone_detectors_enable_o,
  output logic keep_eq_taps_o,
  output logic turnoff_tone_o,
  output logic [11:0] turnoff_freq_o
);
  import htbi_pkg::*;

  // Control registers
  logic [7:0] tone_detect_control, next_tone_detect_control;
  logic [7:0] train_control, next_train_control;
  logic [7:0] turnoff_control, next_turnoff_control;
  logic [7:0] frame_end_control, next_frame_end_control;
  logic [7:0] mode_control, next_mode_control;
  logic tx_empty_irq_enable, next_tx_empty_irq_enable;
  // Buffer and its flags
  logic [7:0] transmit_byte_buffer, next_transmit_byte_buffer;
  logic buf_eof, next_buf_eof; // Frame end captured with the byte
  logic tx_buffer_empty_flag, next_tx_buffer_empty_flag;
  logic tx_empty_irq_active, next_tx_empty_irq_active;
  logic [7:0] rdata, next_rdata;
  // Serializer state
  logic [9:0] shift, next_shift;
  logic [3:0] bits_left, next_bits_left;
  logic shift_eof, next_shift_eof;
  logic tx_bit, next_tx_bit;
  logic frame_end, next_frame_end;
  // Pin synchronisers
  logic rts_meta, rts_sync, rts_prev;
  logic flag_meta, flag_sync;
  // Closing tone
  logic [TONE_CNT_W-1:0] tone_cnt, next_tone_cnt;
  logic [11:0] tone_freq, next_tone_freq;
  logic cts;
  logic wr_buf; // Host loads the buffer this cycle
  logic take; // Serializer takes the buffered byte
  logic flag_pattern_seen;
  assign wr_buf = link.bus_wr && (link.bus_addr == OFS_TXBUF);
  assign take = tx_bit_req_i && (bits_left == 4'h0) && !tx_buffer_empty_flag;
  assign flag_pattern_seen = flag_sync && mode_control[MODE_HDLC];
  // Two-flop synchronisers for pins from outside
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rts_meta <= 1'b0;
      rts_sync <= 1'b0;
      rts_prev <= 1'b0;
      flag_meta <= 1'b0;
      flag_sync <= 1'b0;
      cts <= 1'b0;
    end else begin
      rts_meta <= link.rts;
      rts_sync <= rts_meta;
      rts_prev <= rts_sync;
      flag_meta <= flag_pattern_i;
      flag_sync <= flag_meta;
      cts <= rts_sync; // Clear to send follows request once seen
    end
  end

  // Register writes, buffer flags and read mux
  always_comb begin
    next_tone_detect_control = tone_detect_control;
    next_train_control = train_control;
    next_turnoff_control = turnoff_control;
    next_frame_end_control = frame_end_control;
    next_mode_control = mode_control;
    next_tx_empty_irq_enable = tx_empty_irq_enable;
    next_transmit_byte_buffer = transmit_byte_buffer;
    next_buf_eof = buf_eof;
    next_tx_buffer_empty_flag = tx_buffer_empty_flag;
    next_tx_empty_irq_active = tx_empty_irq_active;
    next_rdata = ZERO_RST;
    if (link.bus_wr) begin
      unique case (link.bus_addr)
        OFS_TONE: next_tone_detect_control = link.bus_wdata;
        OFS_TRAIN: next_train_control = link.bus_wdata;
        OFS_TURNOFF: next_turnoff_control = link.bus_wdata;
        OFS_FRAME: next_frame_end_control = link.bus_wdata;
        OFS_MODE: next_mode_control = link.bus_wdata;
        OFS_IRQ: next_tx_empty_irq_enable = link.bus_wdata[BIT_IEN];
        OFS_TXBUF: begin
          next_transmit_byte_buffer = link.bus_wdata;
          // Frame end only counts in HDLC with the FIFO on
          next_buf_eof = frame_end_control[BIT_EOF] && mode_control[MODE_HDLC]
                         && mode_control[MODE_FIFO];
          next_tx_buffer_empty_flag = 1'b0;
          next_tx_empty_irq_active = 1'b0;
        end
        default: ; // Unmapped writes are dropped
      endcase
    end
    // Taking the byte sets empty; set wins over a same-cycle write
    if (take) begin
      next_tx_buffer_empty_flag = 1'b1;
      if (tx_empty_irq_enable) begin
        next_tx_empty_irq_active = 1'b1;
      end
    end
    if (link.bus_rd) begin
      unique case (link.bus_addr)
        OFS_TONE: next_rdata = tone_detect_control;
        OFS_TRAIN: next_rdata = train_control;
        OFS_TURNOFF: next_rdata = turnoff_control;
        OFS_FLAG: next_rdata = {7'h00, flag_pattern_seen};
        OFS_FRAME: next_rdata = frame_end_control;
        OFS_MODE: next_rdata = mode_control;
        OFS_IRQ: begin
          next_rdata[BIT_IACT] = tx_empty_irq_active;
          next_rdata[BIT_IEN] = tx_empty_irq_enable;
          next_rdata[BIT_EMPTY] = tx_buffer_empty_flag;
        end
        default: next_rdata = ZERO_RST; // Buffer and unmapped read as zero
      endcase
    end
  end

  // Register file storage
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tone_detect_control <= TONE_RST;
      train_control <= ZERO_RST;
      turnoff_control <= ZERO_RST;
      frame_end_control <= ZERO_RST;
      mode_control <= ZERO_RST;
      tx_empty_irq_enable <= 1'b0;
      transmit_byte_buffer <= ZERO_RST;
      buf_eof <= 1'b0;
      tx_buffer_empty_flag <= 1'b1;
      tx_empty_irq_active <= 1'b0;
      rdata <= ZERO_RST;
    end else begin
      tone_detect_control <= next_tone_detect_control;
      train_control <= next_train_control;
      turnoff_control <= next_turnoff_control;
      frame_end_control <= next_frame_end_control;
      mode_control <= next_mode_control;
      tx_empty_irq_enable <= next_tx_empty_irq_enable;
      transmit_byte_buffer <= next_transmit_byte_buffer;
      buf_eof <= next_buf_eof;
      tx_buffer_empty_flag <= next_tx_buffer_empty_flag;
      tx_empty_irq_active <= next_tx_empty_irq_active;
      rdata <= next_rdata;
    end
  end

  // Serializer: one bit per request from the modulator
  always_comb begin
    next_shift = shift;
    next_bits_left = bits_left;
    next_shift_eof = shift_eof;
    next_tx_bit = tx_bit;
    next_frame_end = 1'b0;
    if (tx_bit_req_i) begin
      if (bits_left == 4'h0) begin
        if (take) begin
          if (mode_control[MODE_ASYNC]) begin
            // Start bit, data low bit first, stop bit
            next_shift = {1'b1, transmit_byte_buffer, 1'b0};
            next_bits_left = BITS_ASYNC - 4'h1;
          end else begin
            next_shift = {2'b11, transmit_byte_buffer};
            next_bits_left = BITS_SYNC - 4'h1;
          end
          next_tx_bit = next_shift[0];
          next_shift_eof = buf_eof;
        end else begin
          next_tx_bit = 1'b1; // Idle ones while nothing waits
        end
      end else begin
        next_shift = {1'b1, shift[9:1]};
        next_tx_bit = shift[1];
        next_bits_left = bits_left - 4'h1;
        if (bits_left == 4'h1) begin
          next_frame_end = shift_eof; // Last bit of the final byte
        end
      end
    end
  end
  // Serializer registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      shift <= 10'h3FF;
      bits_left <= 4'h0;
      shift_eof <= 1'b0;
      tx_bit <= 1'b1;
      frame_end <= 1'b0;
    end else begin
      shift <= next_shift;
      bits_left <= next_bits_left;
      shift_eof <= next_shift_eof;
      tx_bit <= next_tx_bit;
      frame_end <= next_frame_end;
    end
  end
  // Closing tone: starts when request to send drops
  always_comb begin
    next_tone_cnt = tone_cnt;
    next_tone_freq = tone_freq;
    if (tone_cnt != '0) begin
      next_tone_cnt = tone_cnt - 1'b1;
    end else if (rts_prev && !rts_sync && turnoff_control[BIT_SOFT_TURNOFF_ENABLE]
                 && mode_control[1:0] != CFG_OTHER) begin
      unique case (mode_control[1:0])
        CFG_V23: begin
          next_tone_freq = HZ_V23;
          next_tone_cnt = TONE_CNT_W'(TONE_SHORT);
        end
        CFG_V21: begin
          next_tone_freq = mode_control[MODE_ANS] ? HZ_V21_ANS : HZ_V21_ORG;
          next_tone_cnt = TONE_CNT_W'(TONE_LONG);
        end
        default: begin
          next_tone_freq = mode_control[MODE_ANS] ? HZ_BELL_ANS : HZ_BELL_ORG;
          next_tone_cnt = TONE_CNT_W'(TONE_LONG);
        end
      endcase
    end
  end
  // Closing tone registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      tone_cnt <= '0;
      tone_freq <= 12'h000;
    end else begin
      tone_cnt <= next_tone_cnt;
      tone_freq <= next_tone_freq;
    end
  end

  assign link.bus_rdata = rdata;
  assign link.irq = tx_empty_irq_active;
  assign link.cts = cts;
  assign tx_bit_o = tx_bit;
  assign frame_end_o = frame_end;
  assign tone_detectors_enable_o = tone_detect_control[BIT_TDE];
  assign keep_eq_taps_o = train_control[BIT_SHORT_TRAIN_SELECT];
  assign turnoff_tone_o = (tone_cnt != '0);
  assign turnoff_freq_o = tone_freq;
endmodule : htbi_device

// ### hdl/htbi_pkg.sv
// Shared constants for the host transmit buffer interface, both ends.
package htbi_pkg;
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int HADDR_W = 4;
  // Device register offsets
  localparam logic [7:0] OFS_TONE = 8'h02;
  localparam logic [7:0] OFS_TRAIN = 8'h04;
  localparam logic [7:0] OFS_TURNOFF = 8'h05;
  localparam logic [7:0] OFS_FLAG = 8'h0A;
  localparam logic [7:0] OFS_TXBUF = 8'h10;
  localparam logic [7:0] OFS_FRAME = 8'h11;
  localparam logic [7:0] OFS_MODE = 8'h12;
  localparam logic [7:0] OFS_IRQ = 8'h1E;
  // Device field positions
  localparam int BIT_TDE = 7;
  localparam int BIT_SHORT_TRAIN_SELECT = 0;
  localparam int BIT_SOFT_TURNOFF_ENABLE = 1;
  localparam int BIT_FLAG_PATTERN_SEEN = 0;
  localparam int BIT_EOF = 1;
  localparam int BIT_EMPTY = 3;
  localparam int BIT_IEN = 5;
  localparam int BIT_IACT = 7;
  localparam int MODE_ANS = 2;
  localparam int MODE_ASYNC = 3;
  localparam int MODE_HDLC = 4;
  localparam int MODE_FIFO = 5;
  // Reset values
  localparam logic [7:0] TONE_RST = 8'h80;
  localparam logic [7:0] ZERO_RST = 8'h00;
  // Line configuration codes, mode bits 1..0
  localparam logic [1:0] CFG_OTHER = 2'h0;
  localparam logic [1:0] CFG_V23 = 2'h1;
  localparam logic [1:0] CFG_V21 = 2'h2;
  localparam logic [1:0] CFG_BELL = 2'h3;
  // Closing tone frequencies in Hz
  localparam logic [11:0] HZ_V23 = 12'h384;
  localparam logic [11:0] HZ_V21_ORG = 12'h370;
  localparam logic [11:0] HZ_V21_ANS = 12'h60E;
  localparam logic [11:0] HZ_BELL_ORG = 12'h55A;
  localparam logic [11:0] HZ_BELL_ANS = 12'h915;
  // Closing tone durations
  localparam int CLK_HZ = 40_000_000;
  localparam int TONE_SHORT_MS = 7;
  localparam int TONE_LONG_MS = 30;
  localparam int TONE_SHORT_CYC = CLK_HZ / 1000 * TONE_SHORT_MS;
  localparam int TONE_LONG_CYC = CLK_HZ / 1000 * TONE_LONG_MS;
  localparam int TONE_CNT_W = 21;
  // Character framing
  localparam logic [3:0] BITS_SYNC = 4'h8;
  localparam logic [3:0] BITS_ASYNC = 4'hA;
  // Host command port offsets
  localparam logic [3:0] H_DATA = 4'h0;
  localparam logic [3:0] H_CTRL = 4'h1;
  localparam logic [3:0] H_STATUS = 4'h2;
  localparam logic [3:0] H_RADDR = 4'h3;
  localparam logic [3:0] H_RWRITE = 4'h4;
  localparam logic [3:0] H_RREAD = 4'h5;
  localparam logic [3:0] H_RRDATA = 4'h6;
  // Host field positions
  localparam int CTRL_RTS = 0;
  localparam int CTRL_EOF = 1;
  localparam int ST_PEND = 0;
  localparam int ST_CTS = 1;
  localparam int ST_IRQ = 2;
  localparam int ST_RAW = 3;
endpackage : htbi_pkg

// ### hdl/htbi_if.sv
// Interface joining the host controller and the data pump's interface memory.
`timescale 1ns/1ps
interface htbi_if;
  logic [htbi_pkg::ADDR_W-1:0] bus_addr; // Register offset
  logic [htbi_pkg::DATA_W-1:0] bus_wdata; // Write data
  logic bus_wr; // One-cycle write strobe
  logic bus_rd; // One-cycle read strobe
  logic [htbi_pkg::DATA_W-1:0] bus_rdata; // Read data, cycle after strobe
  logic irq; // Interrupt request, high active
  logic rts; // Request to send from host
  logic cts; // Clear to send from pump
  modport device (input bus_addr, bus_wdata, bus_wr, bus_rd, rts,
                  output bus_rdata, irq, cts);
  modport host (output bus_addr, bus_wdata, bus_wr, bus_rd, rts,
                input bus_rdata, irq, cts);
endinterface : htbi_if

// ### hdl/htbi_host.sv
// Host controller end: queues transmit bytes and passes raw register access.
`timescale 1ns/1ps
module htbi_host (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [htbi_pkg::HADDR_W-1:0] addr_i,
  input wire logic [htbi_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [htbi_pkg::DATA_W-1:0] rdata_o,
  htbi_if.host link
);
  import htbi_pkg::*;

  typedef enum {ST_IDLE, ST_POLL, ST_CHECK, ST_SETEOF, ST_LOAD, ST_RAWWAIT} htbi_state_t;

  htbi_state_t state, next_state;
  logic [7:0] pend_byte, next_pend_byte; // Byte waiting for the pump
  logic pend, next_pend;
  logic pend_eof, next_pend_eof;
  logic [1:0] ctrl, next_ctrl; // RTS and frame end for next byte
  logic [7:0] raw_addr, next_raw_addr;
  logic [7:0] raw_wdata, next_raw_wdata;
  logic raw_wr, next_raw_wr; // Raw write pending
  logic raw_rd, next_raw_rd; // Raw read pending
  logic [7:0] raw_rdata, next_raw_rdata;
  logic [7:0] rdata, next_rdata;
  logic [7:0] b_addr, next_b_addr;
  logic [7:0] b_wdata, next_b_wdata;
  logic b_wr, next_b_wr;
  logic b_rd, next_b_rd;
  logic cts_meta, cts_sync, irq_meta, irq_sync;

  // Pins from the pump pass two flops
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cts_meta <= 1'b0;
      cts_sync <= 1'b0;
      irq_meta <= 1'b0;
      irq_sync <= 1'b0;
    end else begin
      cts_meta <= link.cts;
      cts_sync <= cts_meta;
      irq_meta <= link.irq;
      irq_sync <= irq_meta;
    end
  end

  // Command port, sequencer and bus driver
  always_comb begin
    next_state = state;
    next_pend_byte = pend_byte;
    next_pend = pend;
    next_pend_eof = pend_eof;
    next_ctrl = ctrl;
    next_raw_addr = raw_addr;
    next_raw_wdata = raw_wdata;
    next_raw_wr = raw_wr;
    next_raw_rd = raw_rd;
    next_raw_rdata = raw_rdata;
    next_rdata = 8'h00;
    next_b_addr = b_addr;
    next_b_wdata = b_wdata;
    next_b_wr = 1'b0;
    next_b_rd = 1'b0;
    if (wr_i) begin
      unique case (addr_i)
        H_DATA: begin
          // Ignored while a byte is still pending
          if (!pend) begin
            next_pend_byte = wdata_i;
            next_pend = 1'b1;
            next_pend_eof = ctrl[CTRL_EOF];
          end
        end
        H_CTRL: next_ctrl = wdata_i[1:0];
        H_RADDR: next_raw_addr = wdata_i;
        H_RWRITE: begin
          next_raw_wdata = wdata_i;
          next_raw_wr = 1'b1;
        end
        H_RREAD: next_raw_rd = (raw_addr != OFS_TXBUF); // Buffer is never read
        default: ;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        H_CTRL: next_rdata = {6'h00, ctrl};
        H_STATUS: next_rdata = {4'h0, raw_wr | raw_rd, irq_sync, cts_sync, pend};
        H_RADDR: next_rdata = raw_addr;
        H_RRDATA: next_rdata = raw_rdata;
        default: next_rdata = 8'h00;
      endcase
    end
    unique case (state)
      ST_IDLE: begin
        if (raw_wr) begin
          next_b_addr = raw_addr;
          next_b_wdata = raw_wdata;
          next_b_wr = 1'b1;
          next_raw_wr = 1'b0;
        end else if (raw_rd) begin
          next_b_addr = raw_addr;
          next_b_rd = 1'b1;
          next_state = ST_RAWWAIT;
        end else if (pend && cts_sync && ctrl[CTRL_RTS]) begin
          next_b_addr = OFS_IRQ;
          next_b_rd = 1'b1;
          next_state = ST_POLL;
        end
      end
      ST_POLL: next_state = ST_CHECK; // Strobe on the bus now
      ST_CHECK: begin
        // Read data of the poll stands now
        if (link.bus_rdata[BIT_EMPTY]) begin
          next_b_addr = OFS_FRAME;
          next_b_wdata = {6'h00, pend_eof, 1'b0}; // Set or clear before each byte
          next_b_wr = 1'b1;
          next_state = ST_SETEOF;
        end else begin
          next_state = ST_IDLE;
        end
      end
      ST_SETEOF: begin
        next_b_addr = OFS_TXBUF;
        next_b_wdata = pend_byte;
        next_b_wr = 1'b1;
        next_pend = 1'b0;
        next_state = ST_LOAD;
      end
      ST_LOAD: next_state = ST_IDLE;
      ST_RAWWAIT: begin
        if (!b_rd) begin
          next_raw_rdata = link.bus_rdata;
          next_raw_rd = 1'b0;
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // Host registers
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      pend_byte <= 8'h00;
      pend <= 1'b0;
      pend_eof <= 1'b0;
      ctrl <= 2'h0;
      raw_addr <= 8'h00;
      raw_wdata <= 8'h00;
      raw_wr <= 1'b0;
      raw_rd <= 1'b0;
      raw_rdata <= 8'h00;
      rdata <= 8'h00;
      b_addr <= 8'h00;
      b_wdata <= 8'h00;
      b_wr <= 1'b0;
      b_rd <= 1'b0;
    end else begin
      state <= next_state;
      pend_byte <= next_pend_byte;
      pend <= next_pend;
      pend_eof <= next_pend_eof;
      ctrl <= next_ctrl;
      raw_addr <= next_raw_addr;
      raw_wdata <= next_raw_wdata;
      raw_wr <= next_raw_wr;
      raw_rd <= next_raw_rd;
      raw_rdata <= next_raw_rdata;
      rdata <= next_rdata;
      b_addr <= next_b_addr;
      b_wdata <= next_b_wdata;
      b_wr <= next_b_wr;
      b_rd <= next_b_rd;
    end
  end

  assign link.bus_addr = b_addr;
  assign link.bus_wdata = b_wdata;
  assign link.bus_wr = b_wr;
  assign link.bus_rd = b_rd;
  assign link.rts = ctrl[CTRL_RTS];
  assign rdata_o = rdata;
endmodule : htbi_host

// ### sim/htbi_checker.sv
// Checker of the register link between host controller and pump.
`timescale 1ns/1ps
module htbi_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [7:0] bus_rdata,
  input wire logic irq,
  input wire logic rts,
  input wire logic cts
);
  import htbi_pkg::*;
  // One domain, so clock and reset are given once
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // Buffer loads only while the line is requested
  buf_wr_rts_a: assert property (bus_wr && bus_addr == OFS_TXBUF |-> rts)
    else $error("buffer written without rts");
  // Loading before clearance would send into a dead line
  buf_wr_cts_a: assert property (bus_wr && bus_addr == OFS_TXBUF |-> cts)
    else $error("buffer written before cts");
  // The buffer is write only, in every mode
  no_buf_rd_a: assert property (bus_rd |-> bus_addr != OFS_TXBUF)
    else $error("buffer read by host");
  // Strobes never overlap
  strobe_excl_a: assert property (!(bus_wr && bus_rd))
    else $error("write and read strobes together");
  // A load withdraws the empty interrupt one cycle on
  load_clr_irq_a: assert property (bus_wr && bus_addr == OFS_TXBUF |=> !irq)
    else $error("irq still up after buffer load");
  // Active flag only ever stands beside a set empty flag
  act_needs_empty_a: assert property ($past(bus_rd) && $past(bus_addr) == OFS_IRQ
    && !bus_rdata[BIT_EMPTY] |-> !bus_rdata[BIT_IACT])
    else $error("active flag without empty flag");
  // Clearance follows a steady request
  cts_rise_a: assert property (rts [*6] |-> cts)
    else $error("cts missing after steady rts");
  // Clearance falls after the request is withdrawn
  cts_fall_a: assert property (!rts [*6] |-> !cts)
    else $error("cts stuck after rts dropped");
endmodule : htbi_checker

// ### sim/htbi_bench.sv
// Self-checking bench joining host controller and pump end to end.
`timescale 1ns/1ps
module htbi_bench;
  import htbi_pkg::*;
  logic clk_i; // 40 MHz clock
  logic rst_n_i; // Sync reset, low
  logic [3:0] addr_i; // Command port address
  logic [7:0] wdata_i; // Command port data
  logic wr_i, rd_i; // Command strobes
  logic [7:0] rdata_o; // Command read data
  logic req, flag_in; // Modulator bit request, flag pattern
  logic tx_bit, frame_end, tone_detectors_enable, keep_taps, tone; // Pump outputs
  logic [11:0] freq; // Closing tone frequency
  int bad_count, n_compared, cycles; // Verdict and timeout counters
  htbi_if htbi_if_i ();
  htbi_host htbi_host_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(htbi_if_i.host));
  // Short tones keep the run brief
  htbi_device #(.TONE_SHORT(20), .TONE_LONG(50)) htbi_device_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .link(htbi_if_i.device), .tx_bit_req_i(req),
    .flag_pattern_i(flag_in), .tx_bit_o(tx_bit), .frame_end_o(frame_end),
    .tone_detectors_enable_o(tone_detectors_enable), .keep_eq_taps_o(keep_taps),
    .turnoff_tone_o(tone), .turnoff_freq_o(freq));
  htbi_checker htbi_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .bus_addr(htbi_if_i.bus_addr), .bus_wdata(htbi_if_i.bus_wdata),
    .bus_wr(htbi_if_i.bus_wr), .bus_rd(htbi_if_i.bus_rd),
    .bus_rdata(htbi_if_i.bus_rdata), .irq(htbi_if_i.irq), .rts(htbi_if_i.rts),
    .cts(htbi_if_i.cts));
  // Clock
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Compare and count
  task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Verdict and stop
  task automatic end_sim();
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_sim
  // One-cycle command write
  task automatic hw(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i) begin
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
    end
    @(posedge clk_i) wr_i <= 1'b0;
  endtask : hw
  // One-cycle command read, data taken in the following cycle
  task automatic hr(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i) begin
      addr_i <= a;
      rd_i <= 1'b1;
    end
    @(posedge clk_i) rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : hr
  // Bounded poll of a status bit
  task automatic wait_st(input int b, input logic v);
    logic [7:0] s;
    repeat (60) begin
      hr(H_STATUS, s);
      if (s[b] === v) return;
    end
    check("status wait", {11'h0, v}, {11'h0, s[b]});
  endtask : wait_st
  // Pass-through register access, waiting for the raw cycle to finish
  task automatic raw_wr(input logic [7:0] a, input logic [7:0] d);
    hw(H_RADDR, a);
    hw(H_RWRITE, d);
    wait_st(ST_RAW, 1'b0);
  endtask : raw_wr
  task automatic raw_rd(input logic [7:0] a, output logic [7:0] d);
    hw(H_RADDR, a);
    hw(H_RREAD, 8'h00);
    wait_st(ST_RAW, 1'b0);
    hr(H_RRDATA, d);
  endtask : raw_rd
  // Queue a byte and wait until it reaches the buffer
  task automatic send(input logic [7:0] b);
    hw(H_DATA, b);
    wait_st(ST_PEND, 1'b0);
  endtask : send
  // Mode change after checking that the buffer is seen empty
  task automatic set_mode(input logic [7:0] m);
    logic [7:0] d;
    raw_rd(OFS_IRQ, d);
    check("empty before mode", 12'h001, {11'h0, d[BIT_EMPTY]});
    raw_wr(OFS_MODE, m);
  endtask : set_mode
  // One bit request; frame end may land with the bit or one cycle on
  task automatic take(output logic b, output logic f);
    @(posedge clk_i) req <= 1'b1;
    @(posedge clk_i) req <= 1'b0;
    #1 b = tx_bit;
    f = frame_end;
    @(posedge clk_i) #1 f = f | frame_end;
  endtask : take
  // Reset values of registers and pins
  task automatic t_reset();
    logic [7:0] d;
    raw_rd(OFS_TONE, d);
    check("tone reg", {4'h0, TONE_RST}, {4'h0, d});
    check("tde pin", 12'h001, {11'h0, tone_detectors_enable});
    raw_rd(OFS_IRQ, d);
    check("irq reg", 12'h008, {4'h0, d});
  endtask : t_reset
  // Sync byte LSB first, interrupt, then mark
  task automatic t_sync();
    logic [7:0] v, d;
    logic f, b;
    hw(H_CTRL, 8'h01);
    wait_st(ST_CTS, 1'b1);
    raw_wr(OFS_IRQ, 8'h20);
    // Not a bit palindrome, and top bit low so the mark is seen
    send(8'h35);
    check("irq after load", 12'h000, {11'h0, htbi_if_i.irq});
    raw_rd(OFS_IRQ, d);
    check("irq reg loaded", 12'h020, {4'h0, d});
    for (int i = 0; i < 8; i++) take(v[i], f);
    check("irq after take", 12'h001, {11'h0, htbi_if_i.irq});
    raw_rd(OFS_IRQ, d);
    check("irq reg taken", 12'h0A8, {4'h0, d});
    check("sync byte", 12'h035, {4'h0, v});
    take(b, f);
    check("mark bit", 12'h001, {11'h0, b});
  endtask : t_sync
  // Async framing with the interrupt disabled
  task automatic t_async();
    logic [9:0] v;
    logic f;
    raw_wr(OFS_IRQ, 8'h00);
    set_mode(8'h08);
    send(8'h1D);
    for (int i = 0; i < 10; i++) take(v[i], f);
    check("async char", {2'h0, 1'b1, 8'h1D, 1'b0}, {2'h0, v});
    check("irq masked", 12'h000, {11'h0, htbi_if_i.irq});
  endtask : t_async
  // Frame end marks only the byte loaded with it
  task automatic t_hdlc();
    logic [7:0] v, f;
    set_mode(8'h30);
    hw(H_CTRL, 8'h03);
    send(8'h7E);
    for (int i = 0; i < 8; i++) take(v[i], f[i]);
    check("eof bits", 12'h080, {4'h0, f});
    hw(H_CTRL, 8'h01);
    send(8'h0B);
    for (int i = 0; i < 8; i++) take(v[i], f[i]);
    check("no eof", 12'h000, {4'h0, f});
    check("hdlc byte", 12'h00B, {4'h0, v});
  endtask : t_hdlc
  // Flag seen only in HDLC; level controls reach their pins
  task automatic t_misc();
    logic [7:0] d;
    @(posedge clk_i) flag_in <= 1'b1;
    repeat (4) @(posedge clk_i);
    raw_rd(OFS_FLAG, d);
    check("flag hdlc", 12'h001, {4'h0, d});
    set_mode(8'h00);
    raw_rd(OFS_FLAG, d);
    check("flag other", 12'h000, {4'h0, d});
    @(posedge clk_i) flag_in <= 1'b0;
    raw_wr(OFS_TRAIN, 8'h01);
    check("keep taps", 12'h001, {11'h0, keep_taps});
    raw_wr(OFS_TONE, 8'h00);
    check("tde off", 12'h000, {11'h0, tone_detectors_enable});
  endtask : t_misc
  // Closing tone for V23 originate and for both sides of V21 and Bell
  task automatic t_tone();
    logic [7:0] m [5] = '{8'h01, 8'h02, 8'h06, 8'h03, 8'h07};
    logic [11:0] hz [5] = '{HZ_V23, HZ_V21_ORG, HZ_V21_ANS, HZ_BELL_ORG, HZ_BELL_ANS};
    int len [5] = '{20, 50, 50, 50, 50};
    int n;
    raw_wr(OFS_TURNOFF, 8'h02);
    for (int k = 0; k < 5; k++) begin
      set_mode(m[k]);
      hw(H_CTRL, 8'h01);
      wait_st(ST_CTS, 1'b1);
      hw(H_CTRL, 8'h00);
      n = 0;
      while (tone !== 1'b1 && n < 20) begin
        @(posedge clk_i) #1 n++;
      end
      check("tone freq", hz[k], freq);
      n = 0;
      while (tone === 1'b1 && n < 300) begin
        @(posedge clk_i) #1 n++;
      end
      check("tone length", len[k][11:0], n[11:0]);
    end
    // Other configurations send no closing tone
    set_mode(8'h00);
    hw(H_CTRL, 8'h01);
    wait_st(ST_CTS, 1'b1);
    hw(H_CTRL, 8'h00);
    repeat (8) @(posedge clk_i);
    #1 check("no tone", 12'h000, {11'h0, tone});
  endtask : t_tone
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 30000) begin
      bad_count++;
      end_sim();
    end
  end
  // Main sequence
  initial begin
    {addr_i, wdata_i, wr_i, rd_i, req, flag_in} = '0;
    rst_n_i = 1'b0;
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_reset();
    t_sync();
    t_async();
    t_hdlc();
    t_misc();
    t_tone();
    end_sim();
  end
endmodule : htbi_bench
